// ### logic/ppg_pkg.sv
// Constants and types shared by the parallel programming port files.
package ppg_pkg;

  // ****************************************************************
  // Action codes sampled on each crystal strobe pulse in programming mode while no operation runs
  // ****************************************************************
  localparam logic [1:0] ACT_ADDR = 2'h0;
  localparam logic [1:0] ACT_DATA = 2'h1;
  localparam logic [1:0] ACT_CMD = 2'h2;
  localparam logic [1:0] ACT_IDLE = 2'h3;

  // ****************************************************************
  // Command bytes
  // ****************************************************************
  localparam logic [7:0] CMD_NOP = 8'h00;
  localparam logic [7:0] CMD_ERASE = 8'h80;
  localparam logic [7:0] CMD_WR_FUSE = 8'h40;
  localparam logic [7:0] CMD_WR_LOCK = 8'h20;
  localparam logic [7:0] CMD_WR_FLASH = 8'h10;
  localparam logic [7:0] CMD_WR_EE = 8'h11;
  localparam logic [7:0] CMD_RD_SIG = 8'h08;
  localparam logic [7:0] CMD_RD_FUSE = 8'h04;
  localparam logic [7:0] CMD_RD_FLASH = 8'h02;
  localparam logic [7:0] CMD_RD_EE = 8'h03;

  // ****************************************************************
  // Memory geometry
  // ****************************************************************
  localparam int FL_AW = 13;
  localparam int PG_AW = 6;
  localparam int EE_AW = 9;
  localparam logic [FL_AW-1:0] FL_LAST = 13'h1FFF;
  localparam logic [PG_AW-1:0] PG_LAST = 6'h3F;
  localparam int EE_BYTES = 512;
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] ERASED_BYTE = 8'hFF;

  // ****************************************************************
  // Fuse and lock layout and reset values
  // ****************************************************************
  localparam logic [7:0] FUSE_LO_RST = 8'hD2;
  localparam logic [7:0] FUSE_HI_RST = 8'hFF;
  localparam logic [7:0] LOCK_RST = 8'hFF;
  localparam logic [7:0] FUSE_LO_RSVD = 8'h10;
  localparam logic [7:0] FUSE_HI_RSVD = 8'hF8;
  localparam logic [7:0] LOCK_RSVD = 8'hC0;
  localparam int FLO_BOD_LEVEL = 7;
  localparam int FLO_BOD_EN = 6;
  localparam int FLO_SPI_EN = 5;
  localparam int FHI_BOOT_VEC = 0;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 50;
  localparam int ENTRY_NS = 100;
  localparam logic [1:0] ENTRY_CYC = 2'((ENTRY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
  localparam int T_ERASE_US = 16000;
  localparam int T_FLASH_US = 8000;
  localparam int T_EE_US = 1000;
  localparam int ERASE_CYC = T_ERASE_US * 1000 / CLK_PERIOD_NS;
  localparam int FLASH_CYC = T_FLASH_US * 1000 / CLK_PERIOD_NS;
  localparam int EE_CYC = T_EE_US * 1000 / CLK_PERIOD_NS;
  localparam int TMR_W = 19;
  localparam int PIN_W = 18;

  typedef enum logic [2:0] {EN_OFF, EN_ARMED, EN_GUARD, EN_ACTIVE, EN_FAIL} ppg_entry_type;
  typedef enum logic [1:0] {OP_IDLE, OP_ERASE, OP_PAGE, OP_WAIT} ppg_op_type;

endpackage

// ### logic/ppg_sync.sv
// Two-flop synchroniser for the programming pins.
`timescale 1ns/1ps
`default_nettype none
module ppg_sync (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Pins and synchronised copies
  input wire logic [ppg_pkg::PIN_W-1:0] pin_i,
  output logic [ppg_pkg::PIN_W-1:0] pin_o
);
  import ppg_pkg::*;

  typedef struct packed {
    logic [PIN_W-1:0] meta;
    logic [PIN_W-1:0] stable;
  } ppg_sync_type;

  ppg_sync_type s_q;
  ppg_sync_type s_d;

  // The first stage feeds only the second stage.
  always_comb begin
    s_d.meta = pin_i;
    s_d.stable = s_q.meta;
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign pin_o = s_q.stable;
endmodule
`default_nettype wire

// ### logic/ppg_store.sv
// Flash, EEPROM and page buffer arrays.
`timescale 1ns/1ps
`default_nettype none
module ppg_store (
  // Clock
  input wire logic clk_i,
  // Flash word port
  input wire logic [ppg_pkg::FL_AW-1:0] fl_addr_i,
  input wire logic fl_we_i,
  input wire logic [15:0] fl_wdata_i,
  output logic [15:0] fl_rdata_o,
  // EEPROM byte port
  input wire logic [ppg_pkg::EE_AW-1:0] ee_addr_i,
  input wire logic ee_we_i,
  input wire logic [7:0] ee_wdata_i,
  output logic [7:0] ee_rdata_o,
  // Page buffer
  input wire logic pb_we_i,
  input wire logic pb_hi_i,
  input wire logic [ppg_pkg::PG_AW-1:0] pb_widx_i,
  input wire logic [7:0] pb_wdata_i,
  input wire logic [ppg_pkg::PG_AW-1:0] pb_ridx_i,
  output logic [15:0] pb_rdata_o
);
  import ppg_pkg::*;

  logic [15:0] flash_mem [0:(1<<FL_AW)-1];
  logic [7:0] ee_mem [0:EE_BYTES-1];
  logic [7:0] pb_lo [0:(1<<PG_AW)-1];
  logic [7:0] pb_hi [0:(1<<PG_AW)-1];

  // Reads are combinational so the page sweep can merge old and new in one cycle.
  assign fl_rdata_o = flash_mem[fl_addr_i];
  assign ee_rdata_o = ee_mem[ee_addr_i];
  assign pb_rdata_o = {pb_hi[pb_ridx_i], pb_lo[pb_ridx_i]};

  always_ff @(posedge clk_i) begin
    if (fl_we_i) begin
      flash_mem[fl_addr_i] <= fl_wdata_i;
    end
    if (ee_we_i) begin
      ee_mem[ee_addr_i] <= ee_wdata_i;
    end
    if (pb_we_i && !pb_hi_i) begin
      pb_lo[pb_widx_i] <= pb_wdata_i;
    end
    if (pb_we_i && pb_hi_i) begin
      pb_hi[pb_widx_i] <= pb_wdata_i;
    end
  end
endmodule
`default_nettype wire

// ### logic/ppg_core.sv
// Parallel programming port of the nonvolatile memories.
`timescale 1ns/1ps
`default_nettype none
module ppg_core #(
  parameter int ERASE_CYCLES = ppg_pkg::ERASE_CYC,
  parameter int FLASH_CYCLES = ppg_pkg::FLASH_CYC,
  parameter int EE_CYCLES = ppg_pkg::EE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Reset pin condition
  input wire logic reset_pin_low_i,
  input wire logic reset_pin_hv_i,
  // Programming controls
  input wire logic crystal_input_strobe_i,
  input wire logic action_sel_hi_i,
  input wire logic action_sel_lo_i,
  input wire logic byte_select_a_i,
  input wire logic byte_select_b_i,
  input wire logic page_latch_pulse_i,
  input wire logic write_strobe_b_i,
  input wire logic output_enable_b_i,
  // Data bus
  input wire logic [7:0] data_i,
  output logic [7:0] data_o,
  output logic data_oe_o,
  // Status
  output logic done_status_pin_o,
  output logic prog_mode_o,
  // Fuse and lock state
  output logic brownout_level_fuse_o,
  output logic brownout_enable_fuse_o,
  output logic serial_prog_enable_fuse_o,
  output logic [3:0] clock_source_fuses_o,
  output logic [1:0] boot_size_fuses_o,
  output logic boot_vector_fuse_o,
  output logic [5:0] lock_bits_o
);
  import ppg_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    ppg_entry_type entry;
    logic [1:0] ent_cnt;
    logic bs_ref;
    ppg_op_type op;
    logic [FL_AW-1:0] idx;
    logic [TMR_W-1:0] tmr;
    logic [TMR_W-1:0] tmr_lim;
    logic [7:0] cmd;
    logic [7:0] addr_lo;
    logic [7:0] addr_hi;
    logic [7:0] data;
    logic pb_loaded;
    logic [7:0] fuse_lo;
    logic [7:0] fuse_hi;
    logic [7:0] lock;
    logic [7:0] rd_data;
    logic xs_prev;
    logic pl_prev;
    logic wr_prev;
  } ppg_state_type;

  ppg_state_type s_q;
  ppg_state_type s_d;

  localparam logic [TMR_W-1:0] ERASE_LIM = TMR_W'(ERASE_CYCLES);
  localparam logic [TMR_W-1:0] FLASH_LIM = TMR_W'(FLASH_CYCLES);
  localparam logic [TMR_W-1:0] EE_LIM = TMR_W'(EE_CYCLES);

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  logic [PIN_W-1:0] pin_s;
  logic x_st;
  logic xa_hi;
  logic xa_lo;
  logic bs_a;
  logic bs_b;
  logic pl;
  logic wr_b;
  logic oe_b;
  logic [7:0] din;
  logic rst_low;
  logic hv;

  ppg_sync u_sync (
    .clk_i(clk_i),
    .rst_b_i(rst_b_i),
    .pin_i({reset_pin_hv_i, reset_pin_low_i, data_i, output_enable_b_i, write_strobe_b_i,
            page_latch_pulse_i, byte_select_b_i, byte_select_a_i, action_sel_lo_i,
            action_sel_hi_i, crystal_input_strobe_i}),
    .pin_o(pin_s)
  );

  assign {hv, rst_low, din, oe_b, wr_b, pl, bs_b, bs_a, xa_lo, xa_hi, x_st} = pin_s;

  // ****************************************************************
  // Storage
  // ****************************************************************
  logic [FL_AW-1:0] fl_addr;
  logic fl_we;
  logic [15:0] fl_wdata;
  logic [15:0] fl_rdata;
  logic [EE_AW-1:0] ee_addr;
  logic ee_we;
  logic [7:0] ee_wdata;
  logic [7:0] ee_rdata;
  logic pb_we;
  logic [15:0] pb_rdata;

  ppg_store u_store (
    .clk_i(clk_i),
    .fl_addr_i(fl_addr),
    .fl_we_i(fl_we),
    .fl_wdata_i(fl_wdata),
    .fl_rdata_o(fl_rdata),
    .ee_addr_i(ee_addr),
    .ee_we_i(ee_we),
    .ee_wdata_i(ee_wdata),
    .ee_rdata_o(ee_rdata),
    .pb_we_i(pb_we),
    .pb_hi_i(bs_a),
    .pb_widx_i(s_q.addr_lo[PG_AW-1:0]),
    .pb_wdata_i(s_q.data),
    .pb_ridx_i(s_q.idx[PG_AW-1:0]),
    .pb_rdata_o(pb_rdata)
  );

  // ****************************************************************
  // Next state
  // ****************************************************************
  logic active;
  logic busy;
  logic xs_rise;
  logic pl_rise;
  logic wr_fall;

  always_comb begin
    s_d = s_q;
    active = (s_q.entry == EN_ACTIVE);
    busy = (s_q.op != OP_IDLE);
    xs_rise = x_st && !s_q.xs_prev;
    pl_rise = pl && !s_q.pl_prev;
    wr_fall = !wr_b && s_q.wr_prev;
    s_d.xs_prev = x_st;
    s_d.pl_prev = pl;
    s_d.wr_prev = wr_b;
    pb_we = 1'b0;
    fl_we = 1'b0;
    ee_we = 1'b0;
    // Address lines and word merges; programming only clears bits.
    fl_addr = {s_q.addr_hi[4:0], s_q.addr_lo};
    ee_addr = {s_q.addr_hi[0], s_q.addr_lo};
    fl_wdata = fl_rdata & pb_rdata;
    ee_wdata = ee_rdata & s_q.data;

    // Entry into programming mode.
    unique case (s_q.entry)
      EN_OFF: begin
        if (rst_low && !bs_a && !bs_b) begin
          if (s_q.ent_cnt == ENTRY_CYC - 2'h1) begin
            s_d.entry = EN_ARMED;
          end else begin
            s_d.ent_cnt = s_q.ent_cnt + 2'h1;
          end
        end else begin
          s_d.ent_cnt = 2'h0;
        end
      end
      EN_ARMED: begin
        if (hv) begin
          s_d.entry = EN_GUARD;
          s_d.ent_cnt = 2'h0;
          s_d.bs_ref = bs_a;
        end else if (!rst_low || bs_a || bs_b) begin
          s_d.entry = EN_OFF;
          s_d.ent_cnt = 2'h0;
        end
      end
      EN_GUARD: begin
        if (!hv) begin
          s_d.entry = EN_OFF;
        end else if (bs_a != s_q.bs_ref) begin
          s_d.entry = EN_FAIL;
        end else if (s_q.ent_cnt == ENTRY_CYC - 2'h1) begin
          s_d.entry = EN_ACTIVE;
        end else begin
          s_d.ent_cnt = s_q.ent_cnt + 2'h1;
        end
      end
      EN_ACTIVE, EN_FAIL: begin
        if (!hv) begin
          s_d.entry = EN_OFF;
          s_d.ent_cnt = 2'h0;
          s_d.cmd = CMD_NOP;
          s_d.pb_loaded = 1'b0;
        end
      end
    endcase

    // Byte loading; strobes are ignored while an operation runs.
    if (active && !busy && xs_rise) begin
      unique case ({xa_hi, xa_lo})
        ACT_ADDR: begin
          if (bs_a) begin
            s_d.addr_hi = din;
          end else begin
            s_d.addr_lo = din;
          end
        end
        ACT_DATA: begin
          s_d.data = din;
        end
        ACT_CMD: begin
          s_d.cmd = din;
          if (din == CMD_NOP) begin
            s_d.pb_loaded = 1'b0;
          end
        end
        ACT_IDLE: begin
        end
      endcase
    end

    if (active && !busy && pl_rise && s_q.cmd == CMD_WR_FLASH) begin
      pb_we = 1'b1;
      s_d.pb_loaded = 1'b1;
    end

    // Operations started by the write strobe.
    if (active && !busy && wr_fall) begin
      s_d.tmr = '0;
      s_d.idx = '0;
      case (s_q.cmd)
        CMD_ERASE: begin
          if (!bs_a) begin
            s_d.op = OP_ERASE;
            s_d.tmr_lim = ERASE_LIM;
          end
        end
        CMD_WR_FLASH: begin
          if (s_q.pb_loaded) begin
            s_d.op = OP_PAGE;
            s_d.tmr_lim = FLASH_LIM;
          end
        end
        CMD_WR_EE: begin
          if (!bs_a) begin
            ee_we = 1'b1;
            s_d.op = OP_WAIT;
            s_d.tmr_lim = EE_LIM;
          end
        end
        CMD_WR_FUSE: begin
          if (bs_a) begin
            s_d.fuse_hi = s_q.data | FUSE_HI_RSVD;
          end else begin
            s_d.fuse_lo = s_q.data | FUSE_LO_RSVD;
          end
          s_d.op = OP_WAIT;
          s_d.tmr_lim = EE_LIM;
        end
        CMD_WR_LOCK: begin
          // Programming can only add locks, never remove them.
          s_d.lock = s_q.lock & (s_q.data | LOCK_RSVD);
          s_d.op = OP_WAIT;
          s_d.tmr_lim = EE_LIM;
        end
        default: begin
        end
      endcase
    end

    // Running operations; the busy time is measured from the strobe.
    if (busy) begin
      s_d.tmr = s_q.tmr + TMR_W'(1);
    end
    unique case (s_q.op)
      OP_IDLE: begin
      end
      OP_ERASE: begin
        fl_addr = s_q.idx;
        fl_wdata = ERASED_WORD;
        fl_we = 1'b1;
        ee_addr = s_q.idx[EE_AW-1:0];
        ee_wdata = ERASED_BYTE;
        ee_we = (s_q.idx < FL_AW'(EE_BYTES));
        s_d.idx = s_q.idx + FL_AW'(1);
        if (s_q.idx == FL_LAST) begin
          s_d.lock = LOCK_RST;
          s_d.op = OP_WAIT;
        end
      end
      OP_PAGE: begin
        fl_addr = {s_q.addr_hi[4:0], s_q.addr_lo[7:6], s_q.idx[PG_AW-1:0]};
        fl_we = 1'b1;
        s_d.idx = s_q.idx + FL_AW'(1);
        if (s_q.idx[PG_AW-1:0] == PG_LAST) begin
          s_d.op = OP_WAIT;
        end
      end
      OP_WAIT: begin
        if (s_q.tmr >= s_q.tmr_lim) begin
          s_d.op = OP_IDLE;
        end
      end
    endcase

    // Read data follows the address and byte select every cycle.
    if (s_q.cmd == CMD_RD_FLASH) begin
      s_d.rd_data = bs_a ? fl_rdata[15:8] : fl_rdata[7:0];
    end else if (s_q.cmd == CMD_RD_EE) begin
      s_d.rd_data = ee_rdata;
    end else begin
      s_d.rd_data = ERASED_BYTE;
    end
  end

  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      s_q <= '{entry: EN_OFF, op: OP_IDLE, cmd: CMD_NOP, fuse_lo: FUSE_LO_RST,
               fuse_hi: FUSE_HI_RST, lock: LOCK_RST, rd_data: ERASED_BYTE, default: '0};
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign data_o = s_q.rd_data;
  assign data_oe_o = active && !oe_b;
  assign done_status_pin_o = (s_q.op == OP_IDLE);
  assign prog_mode_o = active;
  assign brownout_level_fuse_o = s_q.fuse_lo[FLO_BOD_LEVEL];
  assign brownout_enable_fuse_o = s_q.fuse_lo[FLO_BOD_EN];
  assign serial_prog_enable_fuse_o = s_q.fuse_lo[FLO_SPI_EN];
  assign clock_source_fuses_o = s_q.fuse_lo[3:0];
  assign boot_size_fuses_o = s_q.fuse_hi[2:1];
  assign boot_vector_fuse_o = s_q.fuse_hi[FHI_BOOT_VEC];
  assign lock_bits_o = s_q.lock[5:0];
endmodule
`default_nettype wire

// ### bench/ppg_core_properties.sv
// Concurrent checks on the pins of the programming port.
`timescale 1ns/1ps
`default_nettype none
module ppg_core_properties #(
  parameter int ERASE_CYCLES = ppg_pkg::ERASE_CYC,
  parameter int EE_CYCLES = ppg_pkg::EE_CYC
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // Watched pins
  input wire logic reset_pin_hv_i,
  input wire logic write_strobe_b_i,
  input wire logic output_enable_b_i,
  input wire logic data_oe_o,
  input wire logic done_status_pin_o,
  input wire logic prog_mode_o,
  input wire logic [5:0] lock_bits_o
);
  import ppg_pkg::*;
  // ****************************************************************
  // Counters and properties
  // ****************************************************************
  int busy_q;
  int wr_age_q;
  // The age saturates, so a strobe long ago never looks recent again.
  always_ff @(posedge clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_q <= 0;
      wr_age_q <= 99;
    end else begin
      busy_q <= done_status_pin_o ? 0 : busy_q + 1;
      wr_age_q <= !write_strobe_b_i ? 0 : (wr_age_q < 99 ? wr_age_q + 1 : 99);
    end
  end
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!rst_b_i);
  chk_oe_tracks_pin: assert property (data_oe_o == (prog_mode_o && !$past(output_enable_b_i, 2)))
    else $error("data drive does not follow output enable");
  chk_oe_release_bus: assert property ($rose(output_enable_b_i) |-> ##[1:2] !data_oe_o)
    else $error("data bus still driven after output enable rose");
  chk_busy_has_cause: assert property ($fell(done_status_pin_o) |-> wr_age_q <= 6)
    else $error("busy without a write strobe");
  chk_busy_min_len: assert property ($rose(done_status_pin_o) |-> busy_q >= EE_CYCLES)
    else $error("busy period too short");
  chk_busy_max_len: assert property (busy_q <= ERASE_CYCLES + 1)
    else $error("busy period too long");
  chk_lock_set_erase: assert property ((lock_bits_o & ~$past(lock_bits_o)) != 6'h00 |-> !done_status_pin_o)
    else $error("lock bit released outside an erase");
  chk_mode_needs_hv: assert property ($rose(prog_mode_o) |-> $past(reset_pin_hv_i, 2))
    else $error("mode entered without high voltage");
  chk_mode_exit_hv: assert property ($fell(reset_pin_hv_i) |-> ##[1:6] !prog_mode_o)
    else $error("mode kept after high voltage dropped");
  cov_mode: cover property ($rose(prog_mode_o));
  cov_long_busy: cover property ($rose(done_status_pin_o) && busy_q > 4 * EE_CYCLES);
  cov_drive: cover property ($rose(data_oe_o));
endmodule
bind ppg_core ppg_core_properties #(.ERASE_CYCLES(ERASE_CYCLES), .EE_CYCLES(EE_CYCLES)) i_ppg_core_properties (
  .clk_i(clk_i), .rst_b_i(rst_b_i), .reset_pin_hv_i(reset_pin_hv_i), .write_strobe_b_i(write_strobe_b_i),
  .output_enable_b_i(output_enable_b_i), .data_oe_o(data_oe_o), .done_status_pin_o(done_status_pin_o),
  .prog_mode_o(prog_mode_o), .lock_bits_o(lock_bits_o)
);
`default_nettype wire

// ### bench/ppg_prog.sv
// Behavioural model of the external parallel programmer.
`timescale 1ns/1ps
`default_nettype none
module ppg_prog (
  // Clock and device outputs
  input wire logic clk_i,
  input wire logic done_i,
  input wire logic [7:0] dev_data_i,
  input wire logic dev_oe_i,
  // Programming pins
  output logic rst_low_o,
  output logic rst_hv_o,
  output logic strobe_o,
  output logic [1:0] act_o,
  output logic bsa_o,
  output logic bsb_o,
  output logic latch_o,
  output logic wr_b_o,
  output logic oe_b_o,
  output logic [7:0] dat_o
);
  import ppg_pkg::*;
  // ****************************************************************
  // Pin sequences, all changed on the falling clock edge
  // ****************************************************************
  initial begin
    {rst_low_o, rst_hv_o, strobe_o, bsa_o, bsb_o, latch_o} = 6'h00;
    {wr_b_o, oe_b_o} = 2'h3;
    act_o = ACT_IDLE;
    dat_o = 8'h00;
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk_i);
  endtask
  // A high second byte select during the low setup must keep the device out of the mode.
  task automatic enter(input logic glitch, input logic bsb);
    rst_low_o = 1'b1;
    bsb_o = bsb;
    tick(4);
    rst_low_o = 1'b0;
    rst_hv_o = 1'b1;
    tick(1);
    bsa_o = glitch;
    tick(2);
    bsa_o = 1'b0;
    bsb_o = 1'b0;
    tick(8);
  endtask
  task automatic leave();
    rst_hv_o = 1'b0;
    tick(8);
  endtask
  // A released bus shows the inverse, so a stale byte never passes as fresh.
  task automatic load(input logic [1:0] a, input logic b, input logic [7:0] v);
    act_o = a;
    bsa_o = b;
    dat_o = v;
    tick(3);
    strobe_o = 1'b1;
    tick(3);
    strobe_o = 1'b0;
    tick(3);
    act_o = ACT_IDLE;
    dat_o = ~v;
    tick(1);
  endtask
  task automatic latch(input logic b);
    bsa_o = b;
    tick(3);
    latch_o = 1'b1;
    tick(3);
    latch_o = 1'b0;
    tick(3);
  endtask
  task automatic write(input logic b, output int n);
    bsa_o = b;
    tick(3);
    wr_b_o = 1'b0;
    tick(3);
    wr_b_o = 1'b1;
    n = 0;
    tick(3);
    while (done_i !== 1'b1 && n < 12000) begin
      n++;
      tick(1);
    end
    bsa_o = 1'b0;
    tick(2);
  endtask
  task automatic read(input logic b, output logic [7:0] v);
    bsa_o = b;
    oe_b_o = 1'b0;
    tick(5);
    v = dev_oe_i ? dev_data_i : 8'hXX;
    oe_b_o = 1'b1;
    tick(3);
  endtask
endmodule
`default_nettype wire

// ### bench/tb.sv
// Self-checking bench for the parallel programming port.
`timescale 1ns/1ps
`default_nettype none
module tb;
  import ppg_pkg::*;
  logic clk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic low, hv, stb, bsa, bsb, lat, wrb, oeb, oe, done, mode;
  logic [1:0] act;
  logic [7:0] din, dout;
  logic [6:0] flo;
  logic [2:0] fhi;
  logic [5:0] locks;
  int err_count = 0;
  int num_checks = 0;
  always #25 clk_i = ~clk_i;
  ppg_core #(.ERASE_CYCLES(9000), .FLASH_CYCLES(80), .EE_CYCLES(10)) i_ppg_core (
    .clk_i(clk_i), .rst_b_i(rst_b_i), .reset_pin_low_i(low), .reset_pin_hv_i(hv),
    .crystal_input_strobe_i(stb), .action_sel_hi_i(act[1]), .action_sel_lo_i(act[0]),
    .byte_select_a_i(bsa), .byte_select_b_i(bsb), .page_latch_pulse_i(lat), .write_strobe_b_i(wrb),
    .output_enable_b_i(oeb), .data_i(din), .data_o(dout), .data_oe_o(oe), .done_status_pin_o(done),
    .prog_mode_o(mode), .brownout_level_fuse_o(flo[6]), .brownout_enable_fuse_o(flo[5]),
    .serial_prog_enable_fuse_o(flo[4]), .clock_source_fuses_o(flo[3:0]), .boot_size_fuses_o(fhi[2:1]),
    .boot_vector_fuse_o(fhi[0]), .lock_bits_o(locks)
  );
  ppg_prog i_ppg_prog (
    .clk_i(clk_i), .done_i(done), .dev_data_i(dout), .dev_oe_i(oe), .rst_low_o(low), .rst_hv_o(hv),
    .strobe_o(stb), .act_o(act), .bsa_o(bsa), .bsb_o(bsb), .latch_o(lat), .wr_b_o(wrb), .oe_b_o(oeb),
    .dat_o(din)
  );
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t ns: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic conclude();
    $display("checks %0d, mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic ld(input logic [1:0] a, input logic b, input logic [7:0] v);
    i_ppg_prog.load(a, b, v);
  endtask
  task automatic wr(input logic b);
    int n;
    i_ppg_prog.write(b, n);
    check({15'h0, n > 0}, 16'h1);
    if (n >= 12000) begin
      err_count++;
      conclude();
    end
  endtask
  task automatic rd(input logic b, input logic [7:0] e);
    logic [7:0] v;
    i_ppg_prog.read(b, v);
    check({8'h00, v}, {8'h00, e});
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset();
    check({6'h0, flo, fhi}, {6'h0, FUSE_LO_RST[7:5], FUSE_LO_RST[3:0], FUSE_HI_RST[2:0]});
    check({10'h0, locks}, {10'h0, LOCK_RST[5:0]});
    check({13'h0, done, mode, oe}, 16'h4);
  endtask
  task automatic t_entry();
    i_ppg_prog.enter(1'b1, 1'b0);
    check({15'h0, mode}, 16'h0);
    i_ppg_prog.leave();
    i_ppg_prog.enter(1'b0, 1'b1);
    check({15'h0, mode}, 16'h0);
    i_ppg_prog.leave();
    i_ppg_prog.enter(1'b0, 1'b0);
    check({15'h0, mode}, 16'h1);
  endtask
  task automatic t_fuse_lock();
    ld(ACT_CMD, 1'b0, CMD_WR_FUSE);
    ld(ACT_DATA, 1'b0, 8'h5A);
    wr(1'b0);
    check({9'h0, flo}, 16'h2A);
    ld(ACT_DATA, 1'b0, 8'h05);
    wr(1'b1);
    check({6'h0, flo, fhi}, {6'h0, 7'h2A, 3'h5});
    ld(ACT_CMD, 1'b0, CMD_WR_LOCK);
    ld(ACT_DATA, 1'b0, 8'hF0);
    wr(1'b0);
    check({10'h0, locks}, 16'h30);
    ld(ACT_DATA, 1'b0, 8'hFF);
    wr(1'b0);
    check({10'h0, locks}, 16'h30);
  endtask
  task automatic t_erase();
    int n;
    ld(ACT_CMD, 1'b0, CMD_ERASE);
    // A write strobe with the high byte selected must not start the erase.
    i_ppg_prog.write(1'b1, n);
    check({15'h0, n > 0}, 16'h0);
    check({10'h0, locks}, 16'h30);
    wr(1'b0);
    check({10'h0, locks}, 16'h3F);
    check({6'h0, flo, fhi}, {6'h0, 7'h2A, 3'h5});
  endtask
  task automatic t_flash();
    logic [7:0] a;
    ld(ACT_CMD, 1'b0, CMD_WR_FLASH);
    for (int i = 0; i < 64; i++) begin
      ld(ACT_ADDR, 1'b0, 8'h40 | 8'(i));
      ld(ACT_DATA, 1'b0, 8'(i));
      i_ppg_prog.latch(1'b0);
      ld(ACT_DATA, 1'b1, 8'h80 | 8'(i));
      i_ppg_prog.latch(1'b1);
    end
    ld(ACT_ADDR, 1'b1, 8'h05);
    wr(1'b0);
    ld(ACT_CMD, 1'b0, CMD_NOP);
    ld(ACT_CMD, 1'b0, CMD_RD_FLASH);
    ld(ACT_ADDR, 1'b1, 8'h05);
    for (int k = 0; k < 3; k++) begin
      a = (k == 0) ? 8'h40 : (k == 1) ? 8'h7F : 8'hBF;
      ld(ACT_ADDR, 1'b0, a);
      rd(1'b0, (a[7:6] == 2'h1) ? (a & 8'h3F) : ERASED_BYTE);
      rd(1'b1, (a[7:6] == 2'h1) ? (8'h80 | (a & 8'h3F)) : ERASED_BYTE);
    end
  endtask
  task automatic t_eeprom();
    ld(ACT_CMD, 1'b0, CMD_WR_EE);
    ld(ACT_ADDR, 1'b1, 8'h01);
    ld(ACT_ADDR, 1'b0, 8'h23);
    ld(ACT_DATA, 1'b1, 8'h5A);
    wr(1'b0);
    ld(ACT_CMD, 1'b0, CMD_RD_EE);
    ld(ACT_IDLE, 1'b0, 8'h02);
    rd(1'b0, 8'h5A);
    ld(ACT_ADDR, 1'b1, 8'h00);
    // This byte is never written: the erased value stands in for a skipped write.
    rd(1'b0, ERASED_BYTE);
    check({15'h0, oe}, 16'h0);
    ld(ACT_CMD, 1'b0, CMD_RD_SIG);
    rd(1'b0, ERASED_BYTE);
    ld(ACT_CMD, 1'b0, CMD_RD_FUSE);
    rd(1'b0, ERASED_BYTE);
  endtask
  initial begin
    repeat (12) @(negedge clk_i);
    rst_b_i = 1'b1;
    @(negedge clk_i);
    t_reset();
    t_entry();
    t_fuse_lock();
    t_erase();
    t_flash();
    t_eeprom();
    i_ppg_prog.leave();
    check({15'h0, mode}, 16'h0);
    conclude();
  end
endmodule
`default_nettype wire
